// >>> servo_io_pkg.sv
// Shared constants and types for the servo terminal function mapper.
// Assumes one 100 MHz clock and a plain one-cycle register port.
package servo_io_pkg;

    // Terminal counts
    localparam int NUM_DI = 8;
    localparam int NUM_DO = 4;

    // Register byte addresses
    localparam logic [7:0] ADDR_DI_CFG    = 8'h00;
    localparam logic [7:0] ADDR_DO_CFG    = 8'h20;
    localparam logic [7:0] ADDR_ROT_THR   = 8'h30;
    localparam logic [7:0] ADDR_AGREE_THR = 8'h34;
    localparam logic [7:0] ADDR_CTRL_STAT = 8'h38;
    localparam logic [7:0] ADDR_PIN_STAT  = 8'h3c;

    // Field positions and reset values
    localparam int INV_BIT = 8;
    localparam logic [15:0] ROT_THR_RST   = 16'h0014;
    localparam logic [15:0] AGREE_THR_RST = 16'h000a;

    // Input function codes
    localparam logic [4:0] FN_OFF          = 5'h00;
    localparam logic [4:0] FN_ENABLE       = 5'h01;
    localparam logic [4:0] FN_FAULT_CLEAR  = 5'h02;
    localparam logic [4:0] FN_FWD_INHIBIT  = 5'h03;
    localparam logic [4:0] FN_REV_INHIBIT  = 5'h04;
    localparam logic [4:0] FN_ZERO_CLAMP   = 5'h05;
    localparam logic [4:0] FN_DEV_CLEAR    = 5'h06;
    localparam logic [4:0] FN_CMD_REVERSE  = 5'h07;
    localparam logic [4:0] FN_ESTOP        = 5'h08;
    localparam logic [4:0] FN_GEAR_SEL     = 5'h09;
    localparam logic [4:0] FN_PULSE_BLOCK  = 5'h0b;
    localparam logic [4:0] FN_SPEED_SEG0   = 5'h0d;
    localparam logic [4:0] FN_SPEED_SEG1   = 5'h0e;
    localparam logic [4:0] FN_SPEED_SEG2   = 5'h0f;
    localparam logic [4:0] FN_MIXED_CTRL   = 5'h11;
    localparam logic [4:0] FN_POS_SEG_RUN  = 5'h14;
    localparam logic [4:0] FN_POS_SEG0     = 5'h15;
    localparam logic [4:0] FN_POS_SEG1     = 5'h16;
    localparam logic [4:0] FN_POS_SEG2     = 5'h17;
    localparam logic [4:0] FN_POS_SEG3     = 5'h18;

    // Output function codes
    localparam logic [7:0] OUT_OFF      = 8'h80;
    localparam logic [7:0] OUT_READY    = 8'h81;
    localparam logic [7:0] OUT_FAULT    = 8'h82;
    localparam logic [7:0] OUT_WARN     = 8'h83;
    localparam logic [7:0] OUT_ROTATING = 8'h84;
    localparam logic [7:0] OUT_ZERO_SPD = 8'h85;
    localparam logic [7:0] OUT_POS_DONE = 8'h86;
    localparam logic [7:0] OUT_POS_NEAR = 8'h87;
    localparam logic [7:0] OUT_SPD_AGREE = 8'h88;

    // Decoded controls toward the drive core
    typedef struct packed {
        logic       servoEnable;
        logic       faultClear;
        logic       fwdInhibit;
        logic       revInhibit;
        logic       zeroClamp;
        logic       devClear;
        logic       cmdReverse;
        logic       estopStop;
        logic       gearSel2;
        logic       pulseBlock;
        logic [2:0] speedSeg;
        logic       mixedCtrl;
        logic       posSegRun;
        logic [3:0] posSeg;
    } ctrl_t;

    // Drive conditions reported on output terminals
    typedef struct packed {
        logic        driveReady;
        logic        faultActive;
        logic        warnActive;
        logic        posDone;
        logic        posNear;
        logic        speedMode;
        logic [15:0] motorSpeed;
        logic [15:0] speedCmd;
    } drive_stat_t;

endpackage : servo_io_pkg

// >>> servo_io_function_mapper.sv
// Maps digital input terminals to drive controls and drive
// conditions to output terminals, by per-terminal function codes.
// Assumes inputs synchronous to clk; speeds are signed rpm words.
//
// Contract
// RQ1: Enable function valid enables motor, invalid prohibits enabling.
// RQ2: Fault clear function valid resets faults and warnings.
// RQ3: Forward inhibit function valid prohibits forward drive.
// RQ4: Reverse inhibit function valid prohibits reverse drive.
// RQ5: Zero clamp function valid enables zero-speed clamping.
// RQ6: Deviation clear function valid clears the deviation counter.
// RQ7: Reverse function valid reverses incoming instruction direction.
// RQ8: Emergency stop invalid stops at zero speed, then locks position.
// RQ9: Gear select valid picks ratio two, invalid ratio one.
// RQ10: Pulse block function valid refuses instruction pulses.
// RQ11: Three speed selection functions form the speed segment number.
// RQ12: Mixed control function valid puts motor in mixed mode.
// RQ13: Position run function valid runs internal position segments.
// RQ14: Four position selection functions form the position segment.
// RQ15: Ready output valid when drive ready to accept enabling.
// RQ16: Fault output valid whenever a fault is detected.
// RQ17: Warning output valid whenever a warning is signalled.
// RQ18: Rotating output valid while speed magnitude exceeds threshold.
// RQ19: Zero-speed output valid while motor is stopped.
// RQ20: Outputs report positioning complete and positioning near.
// RQ21: Speed agree valid in speed mode when error below threshold.
// RQ22: Unused and undefined codes have no effect on anything.
// RQ23: Codes held per terminal; levels taken after terminal polarity.
`timescale 1ns/1ns
module servo_io_function_mapper
    import servo_io_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire logic [7:0]        addr,
    input  wire logic [31:0]       wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [31:0]       rdata,
    input  wire logic [NUM_DI-1:0] diPins,
    output logic      [NUM_DO-1:0] doPins,
    input  wire drive_stat_t       drive,
    output ctrl_t                  ctrl
);

    // Configuration storage
    logic [4:0]  diCode_r [NUM_DI];
    logic [NUM_DI-1:0] diInv_r;
    logic [7:0]  doCode_r [NUM_DO];
    logic [NUM_DO-1:0] doInv_r;
    logic [15:0] rotThr_r;
    logic [15:0] agreeThr_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    ctrl_t       ctrl_r;
    ctrl_t       ctrl_nxt;
    logic [NUM_DO-1:0] doPins_r;
    logic [NUM_DO-1:0] doPins_nxt;
    logic [NUM_DO-1:0] doValid;

    // Address decode
    wire logic       diSel   = (addr[7:5] == ADDR_DI_CFG[7:5]);
    wire logic       doSel   = (addr[7:4] == ADDR_DO_CFG[7:4]);
    wire logic [2:0] diIdx   = addr[4:2];
    wire logic [1:0] doIdx   = addr[3:2];
    wire logic       rotSel  = (addr == ADDR_ROT_THR);
    wire logic       agrSel  = (addr == ADDR_AGREE_THR);
    wire logic       ctlSel  = (addr == ADDR_CTRL_STAT);
    wire logic       pinSel  = (addr == ADDR_PIN_STAT);
    wire logic       wrEn    = wr && ce;
    wire logic       rdEn    = rd && ce;

    // RQ23 polarity applied per terminal
    wire logic [NUM_DI-1:0] diLevel = diPins ^ diInv_r;

    // Per-code hit and assignment maps
    logic [31:0] codeHit;
    logic [31:0] codeSeen;
    always_comb begin
        codeHit  = '0;
        codeSeen = '0;
        for (int i = 0; i < NUM_DI; i++) begin
            codeSeen[diCode_r[i]] = 1'b1;
            if (diLevel[i]) begin
                codeHit[diCode_r[i]] = 1'b1;
            end
        end
        // RQ22 unused code drives nothing
        codeHit[FN_OFF]  = 1'b0;
        codeSeen[FN_OFF] = 1'b0;
    end

    // Control decode, level-for-level
    always_comb begin
        ctrl_nxt = '0;
        // RQ1 enable follows its level
        ctrl_nxt.servoEnable = codeHit[FN_ENABLE];
        // RQ2 fault clear request
        ctrl_nxt.faultClear  = codeHit[FN_FAULT_CLEAR];
        // RQ3 forward inhibit
        ctrl_nxt.fwdInhibit  = codeHit[FN_FWD_INHIBIT];
        // RQ4 reverse inhibit
        ctrl_nxt.revInhibit  = codeHit[FN_REV_INHIBIT];
        // RQ5 zero-speed clamp
        ctrl_nxt.zeroClamp   = codeHit[FN_ZERO_CLAMP];
        // RQ6 deviation counter clear
        ctrl_nxt.devClear    = codeHit[FN_DEV_CLEAR];
        // RQ7 instruction reversal
        ctrl_nxt.cmdReverse  = codeHit[FN_CMD_REVERSE];
        // RQ8 stop only when assigned and invalid
        ctrl_nxt.estopStop   = codeSeen[FN_ESTOP] && !codeHit[FN_ESTOP];
        // RQ9 gear ratio two when valid
        ctrl_nxt.gearSel2    = codeHit[FN_GEAR_SEL];
        // RQ10 pulse acceptance block
        ctrl_nxt.pulseBlock  = codeHit[FN_PULSE_BLOCK];
        // RQ11 speed segment bits
        ctrl_nxt.speedSeg    = {codeHit[FN_SPEED_SEG2],
                                codeHit[FN_SPEED_SEG1],
                                codeHit[FN_SPEED_SEG0]};
        // RQ12 mixed control mode
        ctrl_nxt.mixedCtrl   = codeHit[FN_MIXED_CTRL];
        // RQ13 position segment run
        ctrl_nxt.posSegRun   = codeHit[FN_POS_SEG_RUN];
        // RQ14 position segment bits
        ctrl_nxt.posSeg      = {codeHit[FN_POS_SEG3],
                                codeHit[FN_POS_SEG2],
                                codeHit[FN_POS_SEG1],
                                codeHit[FN_POS_SEG0]};
    end

    // Speed magnitudes; the most negative word reads as 0x8000 unsigned
    wire logic [15:0] absSpd = drive.motorSpeed[15] ?
                               16'(-drive.motorSpeed) : drive.motorSpeed;
    // Difference kept at 18 bits so full-scale opposite speeds cannot wrap
    wire logic [17:0] spdDiff = {{2{drive.motorSpeed[15]}}, drive.motorSpeed}
                              - {{2{drive.speedCmd[15]}}, drive.speedCmd};
    wire logic [17:0] absDiff = spdDiff[17] ? 18'(-spdDiff) : spdDiff;

    // Output conditions
    // RQ18 rotation above threshold
    wire logic rotating  = absSpd > rotThr_r;
    // RQ19 stopped motor
    wire logic zeroSpeed = (absSpd == 16'h0000);
    // RQ21 agreement only in speed mode
    wire logic spdAgree  = drive.speedMode &&
                           (absDiff < {2'b00, agreeThr_r});

    // Output function select per terminal
    always_comb begin
        for (int j = 0; j < NUM_DO; j++) begin
            case (doCode_r[j])
                // RQ15 ready for enabling
                OUT_READY:     doValid[j] = drive.driveReady;
                // RQ16 fault present
                OUT_FAULT:     doValid[j] = drive.faultActive;
                // RQ17 warning present
                OUT_WARN:      doValid[j] = drive.warnActive;
                OUT_ROTATING:  doValid[j] = rotating;
                OUT_ZERO_SPD:  doValid[j] = zeroSpeed;
                // RQ20 positioning complete and near
                OUT_POS_DONE:  doValid[j] = drive.posDone;
                OUT_POS_NEAR:  doValid[j] = drive.posNear;
                OUT_SPD_AGREE: doValid[j] = spdAgree;
                // RQ22 unused or unknown code stays invalid
                default:       doValid[j] = 1'b0;
            endcase
        end
    end

    // RQ23 output polarity applied per terminal
    assign doPins_nxt = doValid ^ doInv_r;

    // Read mux; unmapped addresses read zero
    always_comb begin
        rdata_nxt = '0;
        if (diSel) begin
            rdata_nxt[4:0]     = diCode_r[diIdx];
            rdata_nxt[INV_BIT] = diInv_r[diIdx];
        end else if (doSel) begin
            rdata_nxt[7:0]     = doCode_r[doIdx];
            rdata_nxt[INV_BIT] = doInv_r[doIdx];
        end else if (rotSel) begin
            rdata_nxt[15:0] = rotThr_r;
        end else if (agrSel) begin
            rdata_nxt[15:0] = agreeThr_r;
        end else if (ctlSel) begin
            rdata_nxt[18:0] = ctrl_r;
        end else if (pinSel) begin
            rdata_nxt[NUM_DI-1:0]  = diPins;
            rdata_nxt[19:16]       = doPins_r;
        end
    end

    // Input terminal configuration writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_DI; i++) begin
                diCode_r[i] <= FN_OFF;
            end
            diInv_r <= '0;
        end else if (wrEn && diSel) begin
            diCode_r[diIdx] <= wdata[4:0];
            diInv_r[diIdx]  <= wdata[INV_BIT];
        end
    end

    // Output terminal configuration writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int j = 0; j < NUM_DO; j++) begin
                doCode_r[j] <= OUT_OFF;
            end
            doInv_r <= '0;
        end else if (wrEn && doSel) begin
            doCode_r[doIdx] <= wdata[7:0];
            doInv_r[doIdx]  <= wdata[INV_BIT];
        end
    end

    // Thresholds
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rotThr_r   <= ROT_THR_RST;
            agreeThr_r <= AGREE_THR_RST;
        end else if (wrEn) begin
            if (rotSel) rotThr_r <= wdata[15:0];
            if (agrSel) agreeThr_r <= wdata[15:0];
        end
    end

    // Read data stands from the cycle after the strobe until the next clock-enabled edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_r <= '0;
        end else if (ce) begin
            rdata_r <= rdEn ? rdata_nxt : 32'h0000_0000;
        end
    end

    // Registered terminal results, one cycle from pin to control
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r   <= '0;
            doPins_r <= '0;
        end else if (ce) begin
            ctrl_r   <= ctrl_nxt;
            doPins_r <= doPins_nxt;
        end
    end

    assign ctrl   = ctrl_r;
    assign doPins = doPins_r;
    assign rdata  = rdata_r;

    // Checks on decode and output mapping
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    enable_map_a: assert property ( // RQ1
        ce |=> ctrl_r.servoEnable == $past(codeHit[FN_ENABLE]))
        else $error("enable does not follow its terminal");

    fault_clear_a: assert property ( // RQ2
        ce |=> ctrl_r.faultClear == $past(codeHit[FN_FAULT_CLEAR]))
        else $error("fault clear mismatch");

    estop_stop_a: assert property ( // RQ8
        ce && codeSeen[FN_ESTOP] && !codeHit[FN_ESTOP] |=> ctrl_r.estopStop)
        else $error("emergency stop not raised");

    estop_idle_a: assert property ( // RQ8
        ce && !codeSeen[FN_ESTOP] |=> !ctrl_r.estopStop)
        else $error("stop raised with no terminal assigned");

    speed_seg_a: assert property ( // RQ11
        ce |=> ctrl_r.speedSeg == $past(codeHit[FN_SPEED_SEG2:FN_SPEED_SEG0]))
        else $error("speed segment mismatch");

    pos_seg_a: assert property ( // RQ14
        ce |=> ctrl_r.posSeg == $past(codeHit[FN_POS_SEG3:FN_POS_SEG0]))
        else $error("position segment mismatch");

    fault_out_a: assert property ( // RQ16
        ce && doCode_r[0] == OUT_FAULT
        |=> doPins_r[0] == ($past(drive.faultActive) ^ $past(doInv_r[0])))
        else $error("fault output wrong");

    rot_out_a: assert property ( // RQ18
        ce && doCode_r[1] == OUT_ROTATING && !doInv_r[1]
        |=> doPins_r[1] == ($past(absSpd) > $past(rotThr_r)))
        else $error("rotation output wrong");

    agree_mode_a: assert property ( // RQ21
        ce && doCode_r[2] == OUT_SPD_AGREE && !drive.speedMode
        |=> doPins_r[2] == $past(doInv_r[2]))
        else $error("speed agree valid outside speed mode");

    unused_out_a: assert property ( // RQ22
        ce && doCode_r[3] == OUT_OFF |=> doPins_r[3] == $past(doInv_r[3]))
        else $error("unused output not at invalid level");

    fwd_inhibit_a: assert property ( // RQ3
        ce |=> ctrl_r.fwdInhibit == $past(codeHit[FN_FWD_INHIBIT]))
        else $error("forward inhibit mismatch");

    rev_inhibit_a: assert property ( // RQ4
        ce |=> ctrl_r.revInhibit == $past(codeHit[FN_REV_INHIBIT]))
        else $error("reverse inhibit mismatch");

    zero_clamp_a: assert property ( // RQ5
        ce |=> ctrl_r.zeroClamp == $past(codeHit[FN_ZERO_CLAMP]))
        else $error("zero clamp mismatch");

    dev_clear_a: assert property ( // RQ6
        ce |=> ctrl_r.devClear == $past(codeHit[FN_DEV_CLEAR]))
        else $error("deviation clear mismatch");

    cmd_reverse_a: assert property ( // RQ7
        ce |=> ctrl_r.cmdReverse == $past(codeHit[FN_CMD_REVERSE]))
        else $error("instruction reverse mismatch");

    gear_sel_a: assert property ( // RQ9
        ce |=> ctrl_r.gearSel2 == $past(codeHit[FN_GEAR_SEL]))
        else $error("gear select mismatch");

    pulse_block_a: assert property ( // RQ10
        ce |=> ctrl_r.pulseBlock == $past(codeHit[FN_PULSE_BLOCK]))
        else $error("pulse block mismatch");

    mixed_ctrl_a: assert property ( // RQ12
        ce |=> ctrl_r.mixedCtrl == $past(codeHit[FN_MIXED_CTRL]))
        else $error("mixed control mismatch");

    pos_run_a: assert property ( // RQ13
        ce |=> ctrl_r.posSegRun == $past(codeHit[FN_POS_SEG_RUN]))
        else $error("position run mismatch");

    ready_out_a: assert property ( // RQ15
        ce && doCode_r[0] == OUT_READY
        |=> doPins_r[0] == ($past(drive.driveReady) ^ $past(doInv_r[0])))
        else $error("ready output wrong");

    warn_out_a: assert property ( // RQ17
        ce && doCode_r[1] == OUT_WARN
        |=> doPins_r[1] == ($past(drive.warnActive) ^ $past(doInv_r[1])))
        else $error("warning output wrong");

    zero_out_a: assert property ( // RQ19
        ce && doCode_r[3] == OUT_ZERO_SPD
        |=> doPins_r[3] == ($past(drive.motorSpeed == 16'h0000) ^ $past(doInv_r[3])))
        else $error("zero speed output wrong");

    pos_done_a: assert property ( // RQ20
        ce && doCode_r[2] == OUT_POS_DONE
        |=> doPins_r[2] == ($past(drive.posDone) ^ $past(doInv_r[2])))
        else $error("positioning complete output wrong");

    pos_near_a: assert property ( // RQ20
        ce && doCode_r[1] == OUT_POS_NEAR
        |=> doPins_r[1] == ($past(drive.posNear) ^ $past(doInv_r[1])))
        else $error("positioning near output wrong");

    agree_out_a: assert property ( // RQ21
        ce && doCode_r[2] == OUT_SPD_AGREE && drive.speedMode && agreeThr_r != 16'h0000
        && drive.motorSpeed == drive.speedCmd |=> doPins_r[2] == !$past(doInv_r[2]))
        else $error("speed agree missing at equal speeds");

    undef_out_a: assert property ( // RQ22
        ce && doCode_r[0] > OUT_SPD_AGREE |=> doPins_r[0] == $past(doInv_r[0]))
        else $error("undefined output code not invalid");

    // A clocked-in cycle with no strobe must clear the read data
    read_once_a: assert property (
        $past(ce) && !$past(rd) |-> rdata_r == 32'h0000_0000)
        else $error("read data outside its cycle");

    enable_cov: cover property (ce && codeHit[FN_ENABLE] ##1 ctrl_r.servoEnable);
    estop_cov:  cover property (ctrl_r.estopStop ##1 !ctrl_r.estopStop);
    agree_cov:  cover property (ce && spdAgree && doCode_r[2] == OUT_SPD_AGREE);

endmodule : servo_io_function_mapper

// >>> servo_ctrl_model.sv
// Motion controller model wired to the drive's digital input terminals.
// Assumes the bench asks for levels; terminals follow one clock later.
`timescale 1ns/1ns
module servo_ctrl_model
    import servo_io_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [NUM_DI-1:0] pinReq,
    output logic      [NUM_DI-1:0] diPins
);
    // Push-pull outputs, so the terminals always carry a real level
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            diPins <= '0;
        end else begin
            diPins <= pinReq;
        end
    end
endmodule : servo_ctrl_model

// >>> servo_io_function_mapper_tb.sv
// Self-checking bench for the terminal function mapper, random setups.
// Assumes a 100 MHz clock and the controller model on the inputs.
`timescale 1ns/1ns
module servo_io_function_mapper_tb;
    import servo_io_pkg::*;
    logic              clk, rst, ce, wr, rd;
    logic [7:0]        addr;
    logic [31:0]       wdata, rdata;
    logic [NUM_DI-1:0] pinReq, diPins;
    logic [NUM_DO-1:0] doPins, expD;
    drive_stat_t       drive;
    ctrl_t             ctrl, expC;
    int                n_errors, checks, seed, rotThr, agreeThr;
    int                diCode[NUM_DI], diInv[NUM_DI], doCode[NUM_DO], doInv[NUM_DO];

    servo_io_function_mapper u_servo_io_function_mapper (.clk(clk), .rst(rst), .ce(ce),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .diPins(diPins),
        .doPins(doPins), .drive(drive), .ctrl(ctrl));
    servo_ctrl_model u_servo_ctrl_model (.clk(clk), .rst(rst), .pinReq(pinReq),
        .diPins(diPins));

    // Free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Decoded controls; several terminals on one code are ORed
    function automatic ctrl_t exp_ctrl();
        int fn[32] = '{default: 0};
        bit stopUsed = 1'b0;
        for (int i = 0; i < NUM_DI; i++) begin
            fn[diCode[i]] |= int'(diPins[i]) ^ diInv[i];
            if (diCode[i] == 8) stopUsed = 1'b1;
        end
        return {fn[1][0], fn[2][0], fn[3][0], fn[4][0], fn[5][0], fn[6][0], fn[7][0],
                stopUsed & ~fn[8][0], fn[9][0], fn[11][0], fn[15][0], fn[14][0],
                fn[13][0], fn[17][0], fn[20][0], fn[24][0], fn[23][0], fn[22][0], fn[21][0]};
    endfunction : exp_ctrl

    // Output terminal levels after polarity
    function automatic logic [3:0] exp_do();
        int sp, df;
        logic c;
        logic [3:0] r;
        sp = int'($signed(drive.motorSpeed));
        df = sp - int'($signed(drive.speedCmd));
        sp = (sp < 0) ? -sp : sp;
        df = (df < 0) ? -df : df;
        for (int j = 0; j < NUM_DO; j++) begin
            case (doCode[j])
                129: c = drive.driveReady;
                130: c = drive.faultActive;
                131: c = drive.warnActive;
                132: c = sp > rotThr;
                133: c = sp == 0;
                134: c = drive.posDone;
                135: c = drive.posNear;
                136: c = drive.speedMode && (df < agreeThr);
                default: c = 1'b0;
            endcase
            r[j] = c ^ doInv[j][0];
        end
        return r;
    endfunction : exp_do

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rd_chk

    // Random terminal codes, polarities and thresholds
    task automatic config_all();
        for (int i = 0; i < NUM_DI; i++) begin
            diCode[i] = $random(seed) & 31;
            diInv[i]  = $random(seed) & 1;
            wr_reg(8'(ADDR_DI_CFG + 4 * i), 32'(diCode[i] + 256 * diInv[i]));
        end
        for (int j = 0; j < NUM_DO; j++) begin
            doCode[j] = 128 + ($random(seed) & 15);
            doInv[j]  = $random(seed) & 1;
            wr_reg(8'(ADDR_DO_CFG + 4 * j), 32'(doCode[j] + 256 * doInv[j]));
        end
        rotThr   = $random(seed) & 31;
        agreeThr = $random(seed) & 31;
        wr_reg(ADDR_ROT_THR, 32'(rotThr));
        wr_reg(ADDR_AGREE_THR, 32'(agreeThr));
    endtask : config_all

    // Speeds in coarse steps so zero and the thresholds are hit often
    task automatic apply_rand();
        drive_stat_t d;
        d = '0;
        d[37:32]     = 6'($random(seed));
        d.motorSpeed = 16'(($random(seed) % 5) * 8);
        d.speedCmd   = d.motorSpeed + 16'($random(seed) % 8);
        // Now and then full-scale opposite speeds, to reach the wrap hazard
        if (($random(seed) & 7) == 0) begin
            d.motorSpeed = 16'h7ff8 - d.motorSpeed;
            d.speedCmd   = 16'h8008 + d.speedCmd;
        end
        @(posedge clk);
        pinReq <= NUM_DI'($random(seed));
        drive  <= d;
        repeat (2) @(posedge clk);
        #1;
        chk(32'(ctrl), 32'(exp_ctrl()));
        chk(32'(doPins), 32'(exp_do()));
    endtask : apply_rand

    task automatic give_verdict();
        $display("Comparisons %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    // Hang guard, well beyond the expected run of some 3k cycles
    initial begin
        #200000;
        n_errors++;
        give_verdict();
    end

    initial begin
        seed = 64023;
        rst = 1'b1;
        ce = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        pinReq = '0;
        drive = '0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd_chk(ADDR_DI_CFG + 8'h1c, 32'h0);
        rd_chk(ADDR_DO_CFG + 8'h0c, 32'h80);
        rd_chk(ADDR_ROT_THR, 32'(ROT_THR_RST));
        rd_chk(ADDR_AGREE_THR, 32'(AGREE_THR_RST));
        wr_reg(8'h40, 32'hffff);
        rd_chk(8'h40, 32'h0);
        $display("Test reset_and_map done");
        for (int n = 0; n < 300; n++) begin
            if (n % 4 == 0) config_all();
            apply_rand();
            if (n % 16 == 0) rd_chk(ADDR_CTRL_STAT, 32'(exp_ctrl()));
            if (n % 16 == 8) rd_chk(ADDR_PIN_STAT, {12'h0, exp_do(), 8'h0, diPins});
        end
        $display("Test random_mapping done");
        // Clock enable low freezes outputs and ignores strobes
        expC = exp_ctrl();
        expD = exp_do();
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(ADDR_ROT_THR, 32'h1ff);
        pinReq <= ~pinReq;
        drive  <= ~drive;
        repeat (3) @(posedge clk);
        #1;
        chk(32'(ctrl), 32'(expC));
        chk(32'(doPins), 32'(expD));
        @(posedge clk);
        ce <= 1'b1;
        rd_chk(ADDR_ROT_THR, 32'(rotThr));
        chk(32'(ctrl), 32'(exp_ctrl()));
        chk(32'(doPins), 32'(exp_do()));
        $display("Test clock_enable done");
        // Reset in mid-run clears outputs and setup
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        #1;
        chk(32'(ctrl), 32'h0);
        chk(32'(doPins), 32'h0);
        @(posedge clk);
        rst <= 1'b0;
        rd_chk(ADDR_DI_CFG, 32'h0);
        $display("Test mid_reset done");
        give_verdict();
    end
endmodule : servo_io_function_mapper_tb
